// File: ledsl_master_model.sv
// Behavioural two-wire bus master facing the LED driver link
`default_nettype none
module ledsl_master (
	// Open-drain pulls, high pulls the line low
	output logic scl_low,
	output logic sda_low,
	// Resolved data line
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam time PH = 80ns;
	initial begin
		scl_low = 0;
		sda_low = 0;
	end
	// Data only changes while the clock is low
	task automatic clk_bit(input logic b, output logic got);
		sda_low = !b;
		#PH;
		scl_low = 0;
		#(PH / 2);
		got = sda;
		#(PH / 2);
		scl_low = 1;
		#PH;
	endtask
	// Called from an idle bus only
	task automatic start();
		sda_low = 1;
		#PH;
		scl_low = 1;
		#PH;
	endtask
	task automatic stop();
		sda_low = 1;
		#PH;
		scl_low = 0;
		#PH;
		sda_low = 0;
		#PH;
	endtask
	// Eight bits then the ninth ack clock; ack_in 0 acks a read byte
	task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
		output logic ack);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(ack_in, ack);
	endtask
	task automatic spike(input time w);
		sda_low = 1;
		#w;
		sda_low = 0;
	endtask
endmodule
`default_nettype wire

// File: ledsl_params.svh
// Constants of the LED driver two-wire slave link
`ifndef LEDSL_PARAMS_SVH
`define LEDSL_PARAMS_SVH
`define LEDSL_CLK_MHZ 250
`define LEDSL_SPIKE_NS 50
// Glitch filter length, least time rounded up to whole cycles
`define LEDSL_SPIKE_CYC ((`LEDSL_SPIKE_NS * `LEDSL_CLK_MHZ + 999) / 1000)
`define LEDSL_TIMEOUT_MS 25
`define LEDSL_TIMEOUT_CYC (`LEDSL_TIMEOUT_MS * `LEDSL_CLK_MHZ * 1000)
`define LEDSL_BYTE_BITS 8
`define LEDSL_BIT_CNT_W 4
`define LEDSL_ACK_SLOT 4'h8
`define LEDSL_ADDR_W 7
`define LEDSL_SLEEP_BIT 4
`define LEDSL_LED_CNT 4
`define LEDSL_ADDR_DEFAULT 7'h62
`endif

// File: ledsl_pkg.sv
// Types of the LED driver two-wire slave link
`default_nettype none
package ledsl_pkg;
	typedef enum logic [2:0] {
		LEDSL_IDLE = 3'b000,
		LEDSL_ADDR = 3'b001,
		LEDSL_RX = 3'b010,
		LEDSL_TX = 3'b011,
		LEDSL_IGNORE = 3'b100
	} ledsl_state_t;
	typedef struct packed {
		logic valid;
		logic first;
		logic [7:0] data;
	} ledsl_rx_t;
	typedef struct packed {
		logic scl;
		logic sda;
	} ledsl_bus_t;
endpackage
`default_nettype wire

// File: ledsl_slave.sv
// Two-wire bus slave link of a four-channel LED driver
// Contract
// RQ1: New transfers begin only after a START, when the bus is idle.
// RQ2: One data bit shifted per serial clock pulse, either direction.
// RQ3: SDA stable while SCL high; changes then are START or STOP.
// RQ4: Both lines high means idle; device releases both lines.
// RQ5: SDA falling with SCL high is START; framing restarts.
// RQ6: SDA rising with SCL high is STOP; back to idle.
// RQ7: Unlimited bytes between START and STOP.
// RQ8: Eight bits plus one acknowledge slot per byte.
// RQ9: Transmitter releases SDA in the acknowledge slot.
// RQ10: Addressed receiver acknowledges every byte.
// RQ11: Master acknowledges each read byte except the last.
// RQ12: Acknowledger holds SDA low over the whole ack clock high.
// RQ13: Master marks last read byte with a not-acknowledge.
// RQ14: After not-acknowledge device releases SDA until STOP.
// RQ15: Sleep bit 4 of first mode register stops oscillator; LEDs freeze.
// RQ16: At reset LED outputs are push-pull at logic high.
// RQ17: SDA or SCL low for the timeout resets the link, if enabled.
// RQ18: Spikes shorter than the spike width are filtered out.
// RQ19: Seven-bit address match, eighth bit selects read or write.
// RQ20: SDA and SCL are synchronised before edge detection.
`include "ledsl_params.svh"
`default_nettype none
module ledsl_slave #(
	parameter int TIMEOUT_CYC = `LEDSL_TIMEOUT_CYC
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic scl_oe,
	output logic sda_out,
	output logic sda_oe,
	// Configuration
	input wire logic [`LEDSL_ADDR_W-1:0] own_address,
	input wire logic timeout_enable,
	input wire logic [7:0] first_mode_control_register,
	// Byte stream, status, oscillator and LED drive
	output ledsl_pkg::ledsl_rx_t rx,
	input wire logic [7:0] tx_data,
	output logic tx_request,
	output logic busy,
	output logic internal_oscillator,
	output logic led_output_drive
);
	import ledsl_pkg::*;
	localparam int FW = 4;
	localparam logic [FW-1:0] FMAX = FW'(`LEDSL_SPIKE_CYC);
	logic [1:0] s1, s2, next_s1, next_s2;
	logic [FW-1:0] fcnt [2];
	logic [FW-1:0] next_fcnt [2];
	ledsl_bus_t filt, next_filt, prev, next_prev;
	logic [31:0] tcnt, next_tcnt;
	ledsl_state_t state, next_state;
	logic [`LEDSL_BIT_CNT_W-1:0] bitc, next_bitc;
	logic [7:0] shreg, next_shreg;
	logic sda_low, next_sda_low, nacked, next_nacked, first, next_first;
	ledsl_rx_t next_rx;
	logic scl_rise, scl_fall, start_c, stop_c, tmo_hit;

	always_comb begin
		next_s1 = {scl_in, sda_in};
		next_s2 = s1; // RQ20
	end

	// Glitch filter per line: level must stand FMAX cycles
	for (genvar g = 0; g < 2; g++) begin : gflt
		always_comb begin
			next_fcnt[g] = '0;
			if (s2[g] != (g == 1 ? filt.scl : filt.sda)) begin
				next_fcnt[g] = fcnt[g] + FW'(1); // RQ18
			end
		end
	end

	always_comb begin
		next_filt = filt;
		if (fcnt[1] >= FMAX - FW'(1) && s2[1] != filt.scl) begin
			next_filt.scl = s2[1]; // RQ18
		end
		if (fcnt[0] >= FMAX - FW'(1) && s2[0] != filt.sda) begin
			next_filt.sda = s2[0]; // RQ18
		end
		next_prev = filt;
	end

	assign scl_rise = filt.scl && !prev.scl;
	assign scl_fall = !filt.scl && prev.scl;
	assign start_c = filt.scl && prev.scl && prev.sda && !filt.sda; // RQ3 RQ5
	assign stop_c = filt.scl && prev.scl && !prev.sda && filt.sda; // RQ3 RQ6
	assign tmo_hit = timeout_enable && tcnt >= 32'(TIMEOUT_CYC) - 32'h1; // RQ17

	// Stuck-low timeout
	always_comb begin
		next_tcnt = '0;
		if (timeout_enable && (!filt.scl || !filt.sda) && tcnt < 32'(TIMEOUT_CYC)) begin
			next_tcnt = tcnt + 32'h1; // RQ17
		end
	end

	always_comb begin
		next_state = state;
		next_bitc = bitc;
		next_shreg = shreg;
		next_sda_low = sda_low;
		next_nacked = nacked;
		next_first = first;
		next_rx = '0;
		if (tmo_hit) begin
			next_state = LEDSL_IDLE; // RQ17
			next_sda_low = 1'b0;
		end else if (stop_c) begin
			next_state = LEDSL_IDLE; // RQ6
			next_sda_low = 1'b0;
		end else if (start_c) begin
			next_state = LEDSL_ADDR; // RQ1 RQ5
			// Ack-slot count, so the SCL fall of the START opens bit 0
			next_bitc = `LEDSL_ACK_SLOT;
			next_sda_low = 1'b0;
			next_nacked = 1'b0;
		end else if (state != LEDSL_IDLE && state != LEDSL_IGNORE) begin
			if (scl_rise) begin
				if (bitc < `LEDSL_ACK_SLOT) begin
					next_shreg = {shreg[6:0], filt.sda}; // RQ2
				end else if (state == LEDSL_TX) begin
					next_nacked = filt.sda; // RQ13 RQ11
				end
			end
			if (scl_fall) begin
				next_bitc = (bitc == `LEDSL_ACK_SLOT) ? '0 : bitc + 4'h1; // RQ8 RQ7
				next_sda_low = 1'b0; // RQ9
				if (bitc == 4'h7) begin
					if (state == LEDSL_ADDR) begin
						if (shreg[7:1] == own_address) begin // RQ19
							next_sda_low = 1'b1; // RQ10 RQ12
							next_state = shreg[0] ? LEDSL_TX : LEDSL_RX;
							next_first = 1'b1;
						end else begin
							next_state = LEDSL_IGNORE;
						end
					end else if (state == LEDSL_RX) begin
						next_sda_low = 1'b1; // RQ10 RQ12
						next_rx = '{valid: 1'b1, first: first, data: shreg};
						next_first = 1'b0;
					end
				end
				if (state == LEDSL_TX && (bitc == `LEDSL_ACK_SLOT || bitc < 4'h7)) begin
					if (bitc == `LEDSL_ACK_SLOT) begin
						next_shreg = tx_data;
						next_sda_low = !tx_data[7] && !nacked; // RQ14
					end else begin
						next_sda_low = !shreg[7] && !nacked; // RQ2
					end
				end
				if (state == LEDSL_TX && bitc == `LEDSL_ACK_SLOT && nacked) begin
					next_state = LEDSL_IGNORE; // RQ14
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s1 <= 2'h3;
			s2 <= 2'h3;
			fcnt[0] <= '0;
			fcnt[1] <= '0;
			filt <= '{scl: 1'b1, sda: 1'b1};
			prev <= '{scl: 1'b1, sda: 1'b1};
			tcnt <= '0;
			state <= LEDSL_IDLE;
			bitc <= '0;
			shreg <= '0;
			sda_low <= 1'b0;
			nacked <= 1'b0;
			first <= 1'b0;
			rx <= '0;
		end else begin
			s1 <= next_s1;
			s2 <= next_s2;
			fcnt[0] <= next_fcnt[0];
			fcnt[1] <= next_fcnt[1];
			filt <= next_filt;
			prev <= next_prev;
			tcnt <= next_tcnt;
			state <= next_state;
			bitc <= next_bitc;
			shreg <= next_shreg;
			sda_low <= next_sda_low;
			nacked <= next_nacked;
			first <= next_first;
			rx <= next_rx;
		end
	end

	assign scl_out = 1'b0;
	assign scl_oe = 1'b0; // RQ4
	assign sda_out = 1'b0;
	assign sda_oe = sda_low && state != LEDSL_IDLE; // RQ4
	assign tx_request = (state == LEDSL_TX) && scl_fall && bitc == 4'h7;
	assign busy = state != LEDSL_IDLE;
	assign internal_oscillator = !first_mode_control_register[`LEDSL_SLEEP_BIT]; // RQ15
	assign led_output_drive = 1'b1; // RQ16

	property p_stop_idle;
		@(posedge ref_clk) disable iff (!reset_n)
		stop_c && !tmo_hit |=> state == LEDSL_IDLE;
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop not to idle"); // RQ6

	property p_start_addr;
		@(posedge ref_clk) disable iff (!reset_n)
		start_c && !stop_c && !tmo_hit
			|=> state == LEDSL_ADDR && bitc == `LEDSL_ACK_SLOT;
	endproperty
	a_start_addr: assert property (p_start_addr) else $error("start not framed"); // RQ5

	property p_idle_release;
		@(posedge ref_clk) disable iff (!reset_n)
		state == LEDSL_IDLE |-> !sda_oe && !scl_oe;
	endproperty
	a_idle_release: assert property (p_idle_release) else $error("drives while idle"); // RQ4

	property p_rx_ack;
		@(posedge ref_clk) disable iff (!reset_n)
		rx.valid |-> sda_oe;
	endproperty
	a_rx_ack: assert property (p_rx_ack) else $error("no ack on byte"); // RQ10

	property p_bit_range;
		@(posedge ref_clk) disable iff (!reset_n)
		bitc <= `LEDSL_ACK_SLOT;
	endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit count over nine"); // RQ8

	property p_sda_stable;
		@(posedge ref_clk) disable iff (!reset_n)
		filt.scl && prev.scl && !start_c && !stop_c && !tmo_hit
			|=> $stable(sda_oe) || !filt.scl;
	endproperty
	a_sda_stable: assert property (p_sda_stable) else $error("sda moved with scl high"); // RQ3

	property p_osc;
		@(posedge ref_clk) disable iff (!reset_n)
		first_mode_control_register[`LEDSL_SLEEP_BIT] |-> !internal_oscillator;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator runs in sleep"); // RQ15

	property p_nack_release;
		@(posedge ref_clk) disable iff (!reset_n)
		state == LEDSL_IGNORE |-> !sda_oe;
	endproperty
	a_nack_release: assert property (p_nack_release) else $error("drives after nack"); // RQ14
endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench of the LED driver two-wire slave link
`include "ledsl_params.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ledsl_pkg::*;
	logic ref_clk, reset_n, timeout_enable, tx_request, busy, osc, drive;
	logic scl_low, sda_low, scl_out, scl_oe, sda_out, sda_oe;
	logic [7:0] mode, tx_data, q;
	logic a;
	ledsl_rx_t rx;
	logic [8:0] got_q[$];
	int n_fail, n_tests, cyc;
	// Pull-ups on both lines
	wire logic sda = !(sda_low | (sda_oe & !sda_out));
	wire logic scl = !(scl_low | (scl_oe & !scl_out));
	ledsl_master m (.scl_low(scl_low), .sda_low(sda_low), .sda(sda));
	ledsl_slave #(.TIMEOUT_CYC(2000)) DUT (.ref_clk(ref_clk), .reset_n(reset_n),
		.scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe(scl_oe),
		.sda_out(sda_out), .sda_oe(sda_oe), .own_address(`LEDSL_ADDR_DEFAULT),
		.timeout_enable(timeout_enable), .first_mode_control_register(mode), .rx(rx),
		.tx_data(tx_data), .tx_request(tx_request), .busy(busy),
		.internal_oscillator(osc), .led_output_drive(drive));
	initial begin
		ref_clk = 0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (rx.valid) got_q.push_back({rx.first, rx.data});
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			wrap_up();
		end
	end
	always @(negedge ref_clk) if (tx_request) tx_data <= 8'h3c;
	task check(input string nm, input logic [8:0] got, input logic [8:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task t_misc;
		check("scl_oe", scl_oe, 0);
		check("sda_oe", sda_oe, 0);
		check("scl_out", scl_out, 0);
		check("sda_out", sda_out, 0);
		m.spike(32ns);
		repeat (30) @(negedge ref_clk);
		check("busy", busy, 0);
		mode = 8'h10;
		@(negedge ref_clk);
		check("osc", osc, 0);
		mode = 8'h00;
		@(negedge ref_clk);
		check("osc", osc, 1);
		check("drive", drive, 1);
	endtask
	task t_write;
		got_q.delete();
		m.start();
		check("busy", busy, 1);
		m.xfer({7'h62, 1'b0}, 1, q, a);
		check("ack", a, 0);
		for (int i = 0; i < 3; i++) begin
			m.xfer(8'h5a ^ 8'(i), 1, q, a);
			check("ack", a, 0);
		end
		m.stop();
		repeat (20) @(negedge ref_clk);
		check("busy", busy, 0);
		check("count", 9'(got_q.size()), 3);
		for (int i = 0; i < 3; i++) check("rx", got_q[i], {i == 0, 8'h5a ^ 8'(i)});
	endtask
	task t_nomatch;
		got_q.delete();
		m.start();
		m.xfer({7'h11, 1'b0}, 1, q, a);
		check("ack", a, 1);
		m.xfer(8'h00, 1, q, a);
		check("ack", a, 1);
		m.stop();
		check("count", 9'(got_q.size()), 0);
	endtask
	task t_read;
		m.start();
		m.xfer({7'h62, 1'b1}, 1, q, a);
		check("ack", a, 0);
		m.xfer(8'hff, 0, q, a);
		check("rd", q, 8'ha5);
		m.xfer(8'hff, 1, q, a);
		check("rd", q, 8'h3c);
		repeat (40) @(negedge ref_clk);
		check("sda_oe", sda_oe, 0);
		m.stop();
		repeat (20) @(negedge ref_clk);
		check("busy", busy, 0);
	endtask
	task t_timeout;
		m.start();
		repeat (2100) @(negedge ref_clk);
		check("busy", busy, 0);
		m.stop();
		timeout_enable = 0;
		m.start();
		repeat (2100) @(negedge ref_clk);
		check("busy", busy, 1);
		m.stop();
	endtask
	initial begin
		reset_n = 0;
		timeout_enable = 1;
		mode = 8'h00;
		tx_data = 8'ha5;
		cyc = 0;
		n_fail = 0;
		n_tests = 0;
		repeat (6) @(negedge ref_clk);
		reset_n = 1;
		@(negedge ref_clk);
		t_misc;
		t_write;
		t_nomatch;
		t_read;
		t_timeout;
		wrap_up;
	end
endmodule
`default_nettype wire
